/* rtl/rcb_pkg.sv */
// Shared constants for the repeater cascade bus block.
// Assumes the core clock runs at 25 MHz; the bus clock is made from it.

package rcb_pkg;

    // ------------------------------------------------------------------
    // Clock figures
    // ------------------------------------------------------------------
    // Core clock rate in Hz
    localparam int unsigned CLK_HZ     = 25_000_000;
    // Serial clock rate driven onto the cascade bus, in Hz
    localparam int unsigned SER_CLK_HZ = 12_500_000;
    // Core cycles per half period of the driven serial clock
    localparam int unsigned HALF_DIV   = CLK_HZ / (2 * SER_CLK_HZ);
    localparam int unsigned DIV_W      = 4;
    localparam logic [DIV_W-1:0] HALF_LAST =
        DIV_W'(HALF_DIV - 1);

    // ------------------------------------------------------------------
    // Stream layout
    // ------------------------------------------------------------------
    // Bits gathered into one received word
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned BIT_CNT_W  = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST =
        BIT_CNT_W'(BYTE_W - 1);
    // Idle serial clock periods kept after the frame drops
    localparam int unsigned TAIL_CLKS  = 2;
    localparam logic [1:0] TAIL_LAST   = 2'(TAIL_CLKS - 1);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [DIV_W-1:0]  DIV_RST  = 4'h0;

    // ------------------------------------------------------------------
    // Bus ownership sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_DRIVE,
        ST_TAIL
    } rcb_state_e;

endpackage : rcb_pkg

/* rtl/rcb_sync.sv */
// Two flip-flop synchroniser for a group of level signals.
// Assumes each bit is an independent level from another domain.
`timescale 1ns/1ps

module rcb_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Levels in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage read only by the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : rcb_sync

/* rtl/rcb_link_rx.sv */
// Receive shifter clocked by the cascade serial clock.
// Assumes the reset is low whenever the frame enable is low, so that each
// frame starts at bit zero even though the clock stops between frames.
`timescale 1ns/1ps

module rcb_link_rx (
    // Link clock and frame reset
    input  wire logic                      lclk,
    input  wire logic                      lrst_n,
    // Bus data sampled on the rising edge
    input  wire logic                      sdata,
    // Word out with toggle for the crossing
    output logic [rcb_pkg::BYTE_W-1:0]     word_q,
    output logic                           word_tgl_q
);

    logic [rcb_pkg::BYTE_W-1:0]    shift_q;
    logic [rcb_pkg::BIT_CNT_W-1:0] cnt_q;

    // Sample data on the rising edge, LSB first
    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            shift_q <= rcb_pkg::BYTE_RST;
            cnt_q   <= '0;
        end else begin
            shift_q <= {sdata, shift_q[rcb_pkg::BYTE_W-1:1]};
            cnt_q   <= cnt_q + 1'b1;
        end
    end

    // Flip the toggle once per word
    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            word_tgl_q <= 1'b0;
        end else if (cnt_q == rcb_pkg::BIT_LAST) begin
            word_tgl_q <= ~word_tgl_q;
        end
    end

    // Word kept over the frame-end reset until the core takes it
    always_ff @(posedge lclk) begin
        if (cnt_q == rcb_pkg::BIT_LAST) begin
            word_q <= {sdata, shift_q[rcb_pkg::BYTE_W-1:1]};
        end
    end

endmodule : rcb_link_rx

/* rtl/rcb_cascade_top.sv */
// Cascade bus end of a hub repeater: arbitration chain, serial stream
// drive and sense, collision line and open-drain activity lines.
// Assumes the segment logic presents bits on request and that all other
// repeaters on the bus share the same wired lines.
`timescale 1ns/1ps

module rcb_cascade_top (
    // Core clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Arbitration chain
    input  wire logic                  arb_ack_in,
    output logic                       arb_ack_out,
    // Serial data line
    input  wire logic                  cascade_serial_data_i,
    output logic                       cascade_serial_data_o,
    output logic                       cascade_serial_data_oe,
    // Framing enable line
    input  wire logic                  cascade_frame_enable_i,
    output logic                       cascade_frame_enable_o,
    output logic                       cascade_frame_enable_oe,
    // Serial clock line, input side is the link clock
    input  wire logic                  cascade_serial_clock_i,
    output logic                       cascade_serial_clock_o,
    output logic                       cascade_serial_clock_oe,
    // Collision line
    input  wire logic                  receive_port_collision_i,
    output logic                       receive_port_collision_o,
    output logic                       receive_port_collision_oe,
    // External transceiver direction
    output logic                       cascade_xcvr_direction,
    // Open-drain activity lines
    output logic                       single_activity_drive_o,
    output logic                       single_activity_drive_oe,
    input  wire logic                  single_activity_sense_n,
    output logic                       multi_activity_drive_o,
    output logic                       multi_activity_drive_oe,
    input  wire logic                  multi_activity_sense_n,
    // Local segment side
    input  wire logic                  seg_rx_active,
    input  wire logic                  seg_rx_bit,
    output logic                       seg_bit_take,
    input  wire logic                  seg_collision,
    input  wire logic                  seg_tx_collision,
    input  wire logic                  seg_multi_collision,
    // Status towards the repeater core
    output logic                       bus_owner,
    output logic                       bus_frame_seen,
    output logic                       bus_collision_seen,
    output logic                       single_activity_seen,
    output logic                       multi_activity_seen,
    output logic [rcb_pkg::BYTE_W-1:0] rx_word,
    output logic                       rx_word_valid
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rcb_pkg::rcb_state_e state_q;
    rcb_pkg::rcb_state_e state_d;

    logic                       ack_in_s;
    logic                       frame_s;
    logic                       coll_s;
    logic                       single_s;
    logic                       multi_s;
    logic                       tgl_s;
    logic                       tgl_seen_q;

    logic [rcb_pkg::DIV_W-1:0]  div_q;
    logic                       half_end;
    logic                       sclk_q;
    logic                       fall_edge;
    logic [1:0]                 tail_q;
    logic                       drive_q;

    logic                       link_rst_n;
    logic [rcb_pkg::BYTE_W-1:0] link_word;
    logic                       link_tgl;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Asynchronous bus pins pass two flops before use
    rcb_sync #(
        .W (5)
    ) u_pin_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({arb_ack_in,
                cascade_frame_enable_i,
                receive_port_collision_i,
                ~single_activity_sense_n,
                ~multi_activity_sense_n}),
        .q    ({ack_in_s, frame_s, coll_s, single_s, multi_s})
    );

    // Word toggle from the link domain
    rcb_sync #(
        .W (1)
    ) u_tgl_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (link_tgl),
        .q    (tgl_s)
    );

    // ------------------------------------------------------------------
    // Link clock domain receiver
    // ------------------------------------------------------------------
    // Held in reset outside frames since the bus clock may stop
    assign link_rst_n = nrst & cascade_frame_enable_i;

    rcb_link_rx u_link_rx (
        .lclk       (cascade_serial_clock_i),
        .lrst_n     (link_rst_n),
        .sdata      (cascade_serial_data_i),
        .word_q     (link_word),
        .word_tgl_q (link_tgl)
    );

    // ------------------------------------------------------------------
    // Ownership sequence
    // ------------------------------------------------------------------
    // Next state, all of it on the core clock
    always_comb begin
        state_d = state_q;
        case (state_q)
            rcb_pkg::ST_IDLE: begin
                if (seg_rx_active) begin
                    state_d = rcb_pkg::ST_REQ;
                end
            end
            rcb_pkg::ST_REQ: begin
                if (!seg_rx_active) begin
                    state_d = rcb_pkg::ST_IDLE;
                end else if (ack_in_s) begin
                    state_d = rcb_pkg::ST_DRIVE;
                end
            end
            rcb_pkg::ST_DRIVE: begin
                if (!seg_rx_active && fall_edge) begin
                    state_d = rcb_pkg::ST_TAIL;
                end
            end
            rcb_pkg::ST_TAIL: begin
                if (fall_edge && tail_q == rcb_pkg::TAIL_LAST) begin
                    state_d = rcb_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = rcb_pkg::ST_IDLE;
            end
        endcase
    end

    // State register on the reference clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= rcb_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Tail period counter after the frame drops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tail_q <= 2'h0;
        end else if (state_q != rcb_pkg::ST_TAIL) begin
            tail_q <= 2'h0;
        end else if (fall_edge) begin
            tail_q <= tail_q + 2'h1;
        end
    end

    // Bus is ours in drive and tail states
    assign drive_q = (state_q == rcb_pkg::ST_DRIVE) ||
                     (state_q == rcb_pkg::ST_TAIL);

    // ------------------------------------------------------------------
    // Arbitration chain
    // ------------------------------------------------------------------
    // Grant passes on only when this device does not want it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arb_ack_out <= 1'b0;
        end else begin
            arb_ack_out <= ack_in_s &&
                           (state_d == rcb_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------------
    // Half period counter, free running only while driving
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= rcb_pkg::DIV_RST;
        end else if (!drive_q || half_end) begin
            div_q <= rcb_pkg::DIV_RST;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign half_end  = drive_q && (div_q == rcb_pkg::HALF_LAST);
    // Falling edge of the driven clock is due this cycle
    assign fall_edge = half_end && sclk_q;

    // Driven serial clock level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
        end else if (!drive_q) begin
            sclk_q <= 1'b0;
        end else if (half_end) begin
            sclk_q <= ~sclk_q;
        end
    end

    // ------------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------------
    // Data changes together with the falling clock edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cascade_serial_data_o <= 1'b0;
            seg_bit_take          <= 1'b0;
        end else begin
            seg_bit_take <= 1'b0;
            if (state_q == rcb_pkg::ST_DRIVE && fall_edge &&
                seg_rx_active) begin
                cascade_serial_data_o <= seg_rx_bit;
                seg_bit_take          <= 1'b1;
            end else if (!drive_q) begin
                cascade_serial_data_o <= 1'b0;
            end
        end
    end

    // Frame enable follows the stream, dropped on a falling edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cascade_frame_enable_o <= 1'b0;
        end else if (state_q == rcb_pkg::ST_DRIVE && fall_edge) begin
            cascade_frame_enable_o <= seg_rx_active;
        end else if (!drive_q) begin
            cascade_frame_enable_o <= 1'b0;
        end
    end

    // Collision line carries the local port collision
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            receive_port_collision_o <= 1'b0;
        end else begin
            receive_port_collision_o <= drive_q && seg_collision;
        end
    end

    // Output enables and direction, inputs by default
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cascade_serial_data_oe    <= 1'b0;
            cascade_frame_enable_oe   <= 1'b0;
            cascade_serial_clock_oe   <= 1'b0;
            receive_port_collision_oe <= 1'b0;
            cascade_xcvr_direction    <= 1'b0;
        end else begin
            cascade_serial_data_oe    <= drive_q;
            cascade_frame_enable_oe   <= drive_q;
            cascade_serial_clock_oe   <= drive_q;
            receive_port_collision_oe <= drive_q;
            cascade_xcvr_direction    <= drive_q;
        end
    end

    // Clock pin takes the divider's next level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cascade_serial_clock_o <= 1'b0;
        end else begin
            cascade_serial_clock_o <= drive_q && (sclk_q ^ half_end);
        end
    end

    // Ownership flag for the core
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_owner <= 1'b0;
        end else begin
            bus_owner <= drive_q;
        end
    end

    // ------------------------------------------------------------------
    // Activity lines
    // ------------------------------------------------------------------
    // Open-drain drivers only ever pull low
    assign single_activity_drive_o = 1'b0;
    assign multi_activity_drive_o  = 1'b0;

    // Pull low while any local segment is active
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            single_activity_drive_oe <= 1'b0;
        end else begin
            single_activity_drive_oe <= seg_rx_active ||
                                        seg_collision;
        end
    end

    // Pull low on transmit or multi-port collision
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            multi_activity_drive_oe <= 1'b0;
        end else begin
            multi_activity_drive_oe <= seg_tx_collision ||
                                       seg_multi_collision;
        end
    end

    // Combined line state seen by all devices
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            single_activity_seen <= 1'b0;
            multi_activity_seen  <= 1'b0;
        end else begin
            single_activity_seen <= single_s;
            multi_activity_seen  <= multi_s;
        end
    end

    // ------------------------------------------------------------------
    // Bus sense
    // ------------------------------------------------------------------
    // Frame and collision from another device on the bus
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_frame_seen     <= 1'b0;
            bus_collision_seen <= 1'b0;
        end else begin
            bus_frame_seen     <= frame_s && !drive_q;
            bus_collision_seen <= coll_s && !drive_q;
        end
    end

    // Toggle edge marks a new received word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_s;
        end
    end

    // Toggle inside a frame; the frame-end reset flip is ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_word       <= rcb_pkg::BYTE_RST;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= 1'b0;
            if ((tgl_s != tgl_seen_q) && frame_s && !drive_q) begin
                rx_word       <= link_word;
                rx_word_valid <= 1'b1;
            end
        end
    end

endmodule : rcb_cascade_top

/* bench/rcb_props_properties.sv */
// Checker on the cascade bus block ports, bound into its top.
// Assumes the core clock domain only; link logic is judged at outputs.
`timescale 1ns/1ps

module rcb_props (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bus lines
    input wire logic arb_ack_in,
    input wire logic arb_ack_out,
    input wire logic cascade_serial_data_o,
    input wire logic cascade_serial_data_oe,
    input wire logic cascade_frame_enable_o,
    input wire logic cascade_frame_enable_oe,
    input wire logic cascade_serial_clock_o,
    input wire logic cascade_serial_clock_oe,
    input wire logic cascade_xcvr_direction,
    input wire logic bus_owner,
    // Activity and segment
    input wire logic single_activity_drive_o,
    input wire logic single_activity_drive_oe,
    input wire logic single_activity_sense_n,
    input wire logic multi_activity_drive_o,
    input wire logic multi_activity_drive_oe,
    input wire logic multi_activity_sense_n,
    input wire logic seg_rx_active,
    input wire logic seg_multi_collision,
    input wire logic seg_bit_take,
    input wire logic single_activity_seen,
    input wire logic multi_activity_seen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------------
    dir_oe_a: assert property (
        cascade_xcvr_direction == bus_owner &&
        cascade_xcvr_direction == cascade_serial_data_oe &&
        cascade_xcvr_direction == cascade_frame_enable_oe &&
        cascade_xcvr_direction == cascade_serial_clock_oe)
        else $error("enables off direction");
    grant_a: assert property (
        $rose(cascade_xcvr_direction) |-> $past(arb_ack_in, 4))
        else $error("drive without grant");
    ack_pass_a: assert property (
        arb_ack_out |-> $past(arb_ack_in, 3))
        else $error("ack out without ack in");
    take_low_a: assert property (
        seg_bit_take |-> !cascade_serial_clock_o && cascade_serial_data_oe)
        else $error("bit taken off fall");
    data_fall_a: assert property (
        cascade_serial_data_oe && $past(cascade_serial_data_oe) &&
        $changed(cascade_serial_data_o) |-> $fell(cascade_serial_clock_o))
        else $error("data changed off fall");
    frame_fall_a: assert property (
        cascade_frame_enable_oe && $changed(cascade_frame_enable_o)
        |-> $fell(cascade_serial_clock_o)) else $error("frame edge wrong");

    // ------------------------------------------------------------------
    // Activity lines
    // ------------------------------------------------------------------
    single_drv_a: assert property (
        seg_rx_active |-> ##[0:4] single_activity_drive_oe)
        else $error("single drive missing");
    multi_drv_a: assert property (
        seg_multi_collision |-> ##[0:4] multi_activity_drive_oe)
        else $error("multi drive missing");
    open_drain_a: assert property (
        !single_activity_drive_o && !multi_activity_drive_o)
        else $error("activity driven high");
    single_sns_a: assert property (
        (!single_activity_sense_n) [*5] |-> single_activity_seen)
        else $error("single sense missed");
    multi_sns_a: assert property (
        (!multi_activity_sense_n) [*5] |-> multi_activity_seen)
        else $error("multi sense missed");

    // Main scenarios reached
    own_c: cover property ($rose(bus_owner));
    take_c: cover property (seg_bit_take);
    seen_c: cover property ($rose(multi_activity_seen));
endmodule : rcb_props

bind rcb_cascade_top rcb_props u_props (.*);

/* bench/rcb_peer.sv */
// Another repeater that sends one frame on the cascade bus.
// Assumes the bench resolves every shared line from all enables.
`timescale 1ns/1ps

module rcb_peer (
    // Bus lines and their enable
    output logic sd,
    output logic fe,
    output logic sc,
    output logic col,
    output logic oe,
    // Activity pulls, high pulls the wired line low
    output logic sact,
    output logic mact
);
    initial {sd, fe, sc, col, oe, sact, mact} = 7'h00;

    // One byte LSB first, clock still outside the frame
    task automatic send(input logic [7:0] b, input logic c);
        int i;
        oe = 1'b1;
        sact = 1'b1;
        mact = c;
        col = c;
        #13 fe = 1'b1;
        sd = b[0];
        for (i = 0; i < 8; i++) begin
            #24 sc = 1'b1;
            #24 sc = 1'b0;
            sd = (i < 7) ? b[i+1] : ~b[7];
        end
        #24 {fe, oe, sact, mact, col} = 5'h00;
    endtask : send
endmodule : rcb_peer

/* bench/tb.sv */
// Bench: the block faces one peer repeater on the bus.
// Assumes the peer model and the bound checker are compiled before it.
`timescale 1ns/1ps

module tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk = 1'b0, nrst = 1'b0, ack = 1'b0, ra = 1'b0, rb = 1'b0;
    logic sc = 1'b0, st = 1'b0, sm = 1'b0, idl = 1'b0;
    logic [31:0] rs = 32'hd9c0;
    int n_errors = 0, checks_done = 0, i;
    logic q [$];
    logic d_o, d_oe, f_o, f_oe, c_o, c_oe, k_o, k_oe, dir, ao;
    logic sa_o, sa_oe, ma_o, ma_oe, take, own, fs, cs, ss, ms, rv;
    logic [7:0] rw;
    logic p_sd, p_fe, p_sc, p_col, p_oe, p_sa, p_ma;
    // Frame, clock, collision pulled low; free data flips
    wire bd = d_oe ? d_o : p_oe ? p_sd : idl;
    wire bf = f_oe ? f_o : p_oe & p_fe;
    wire bc = c_oe ? c_o : p_oe & p_sc;
    wire bk = k_oe ? k_o : p_oe & p_col;
    wire sa_n = !(sa_oe | p_sa);
    wire ma_n = !(ma_oe | p_ma);

    always #20 clk = ~clk;
    always @(posedge clk) idl <= ~idl;

    rcb_cascade_top dut (.clk(clk), .nrst(nrst), .arb_ack_in(ack),
        .arb_ack_out(ao), .cascade_serial_data_i(bd),
        .cascade_serial_data_o(d_o), .cascade_serial_data_oe(d_oe),
        .cascade_frame_enable_i(bf), .cascade_frame_enable_o(f_o),
        .cascade_frame_enable_oe(f_oe), .cascade_serial_clock_i(bc),
        .cascade_serial_clock_o(c_o), .cascade_serial_clock_oe(c_oe),
        .receive_port_collision_i(bk), .receive_port_collision_o(k_o),
        .receive_port_collision_oe(k_oe), .cascade_xcvr_direction(dir),
        .single_activity_drive_o(sa_o), .single_activity_drive_oe(sa_oe),
        .single_activity_sense_n(sa_n), .multi_activity_drive_o(ma_o),
        .multi_activity_drive_oe(ma_oe), .multi_activity_sense_n(ma_n),
        .seg_rx_active(ra), .seg_rx_bit(rb), .seg_bit_take(take),
        .seg_collision(sc), .seg_tx_collision(st),
        .seg_multi_collision(sm), .bus_owner(own), .bus_frame_seen(fs),
        .bus_collision_seen(cs), .single_activity_seen(ss),
        .multi_activity_seen(ms), .rx_word(rw), .rx_word_valid(rv));

    rcb_peer u_peer (.sd(p_sd), .fe(p_fe), .sc(p_sc), .col(p_col),
        .oe(p_oe), .sact(p_sa), .mact(p_ma));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic chk1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Segment bit feed; framed bits queued as expected
    always @(posedge clk) begin
        #1;
        if (take === 1'b1) begin
            if (f_o === 1'b1) q.push_back(rb);
            rs = xs(rs);
            rb = rs[0];
        end
    end

    // Bus data checked at each rising bus clock while this block drives a frame
    always @(posedge bc) begin
        if (dir === 1'b1 && bf === 1'b1) begin
            chk1("stream bit", q.size() ? q.pop_front() : ~bd, bd);
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        wait_clk(16);
        nrst = 1'b1;
        ack = 1'b1;
        wait_clk(6);
        chk1("ack out idle", 1'b1, ao);
        ack = 1'b0;
        wait_clk(4);
        ra = 1'b1;
        wait_clk(20);
        chk1("drive without grant", 1'b0, dir);
        chk1("ack out waiting", 1'b0, ao);
        chk1("single drive", 1'b1, sa_oe);
        ack = 1'b1;
        for (i = 0; i < 10 && own !== 1'b1; i++) wait_clk(1);
        chk1("direction", 1'b1, dir);
        chk1("ack out owner", 1'b0, ao);
        wait_clk(40);
        sc = 1'b1;
        wait_clk(6);
        chk1("collision line", 1'b1, bk);
        sc = 1'b0;
        ra = 1'b0;
        for (i = 0; i < 30 && own !== 1'b0; i++) wait_clk(1);
        chk1("bus released", 1'b0, dir | d_oe | f_oe | c_oe | k_oe);
        // Peer frames, some with collision
        for (int n = 0; n < 3; n++) begin
            rs = xs(rs);
            fork
                u_peer.send(rs[7:0], rs[8]);
                begin
                    wait_clk(6);
                    chk1("frame seen", 1'b1, fs);
                    chk1("single seen", 1'b1, ss);
                    chk1("collision seen", rs[8], cs);
                    chk1("multi seen", rs[8], ms);
                    for (i = 0; i < 40 && rv !== 1'b1; i++) wait_clk(1);
                    chk8("rx word", rs[7:0], rw);
                end
            join
        end
        // Random grant and collision mixes
        for (int n = 0; n < 24; n++) begin
            rs = xs(rs);
            {ack, sc, st, sm} = rs[3:0];
            wait_clk(6);
            chk1("ack chain", ack, ao);
            chk1("single drive", sc, sa_oe);
            chk1("multi drive", st | sm, ma_oe);
            chk1("single seen", sc, ss);
            chk1("multi seen", st | sm, ms);
        end
        complete_run();
    end

    // Hang guard
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule : tb
